// file: hw/cspm_pkg.sv
// Package: constants and types for the card slot power and clock logic
package cspm_pkg;

   // ----------------------------------------
   // Configuration space slot information
   // ----------------------------------------
   localparam logic [7:0] CSPM_SLOT_INFO_OFFSET = 8'h40;
   localparam int         CSPM_SLOTS_LSB        = 4;
   localparam int         CSPM_SLOTS_MSB        = 6;
   localparam int         CSPM_FIRST_WIN_LSB    = 0;
   localparam int         CSPM_FIRST_WIN_MSB    = 2;
   localparam logic [2:0] CSPM_SLOTS_MAX_CODE   = 3'h5;
   localparam logic [2:0] CSPM_FIRST_WIN_MAX    = 3'h5;
   localparam int         CSPM_MAX_SLOTS        = 6;

   // Power-state field codes of the power-management control register
   localparam logic [1:0] CSPM_PS_D0 = 2'h0;
   localparam logic [1:0] CSPM_PS_D1 = 2'h1;
   localparam logic [1:0] CSPM_PS_D2 = 2'h2;
   localparam logic [1:0] CSPM_PS_D3 = 2'h3;

   // Reset values of the host register bits
   localparam logic CSPM_POWER_RST = 1'b0;
   localparam logic CSPM_CLOCK_RST = 1'b0;

   // Card presence tracking states
   typedef enum logic [1:0] {
      CSPM_EMPTY,
      CSPM_PRESENT,
      CSPM_POWERED
   } cspm_card_t;

endpackage

// file: hw/cspm_slot_info.sv
// Read-only slot information byte of configuration space
`timescale 1ns/1ps
module cspm_slot_info
   import cspm_pkg::*;
#(
   parameter logic [2:0] SLOT_CODE = 3'h0,
   parameter logic [2:0] FIRST_WIN = 3'h0
)(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic [7:0] cfg_addr,
   input  wire logic       cfg_rd,
   output logic      [7:0] cfg_rdata
);

   // ----------------------------------------
   // Clamp and pack
   // ----------------------------------------
   // Codes above six slots or beyond the last window are clamped
   wire [2:0] slots_code = (SLOT_CODE > CSPM_SLOTS_MAX_CODE) ?
                           CSPM_SLOTS_MAX_CODE : SLOT_CODE;
   wire [2:0] first_code = (FIRST_WIN > CSPM_FIRST_WIN_MAX) ?
                           CSPM_FIRST_WIN_MAX : FIRST_WIN;
   // Windows used run contiguously and may not pass the last one
   wire [3:0] last_win   = {1'b0, first_code} + {1'b0, slots_code};
   wire [2:0] slots_fit  = (last_win > {1'b0, CSPM_FIRST_WIN_MAX}) ?
                           3'(CSPM_FIRST_WIN_MAX - first_code) : slots_code;
   wire [7:0] info_byte  = {1'b0, slots_fit, 1'b0, first_code};
   wire       hit        = cfg_rd && (cfg_addr == CSPM_SLOT_INFO_OFFSET);

   // Registered read data; zero for any other address
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg_rdata <= 8'h00;
      end else begin
         cfg_rdata <= hit ? info_byte : 8'h00;
      end
   end

endmodule

// file: hw/cspm_top.sv
// Card slot power, clock gating and power-state logic
`timescale 1ns/1ps
module cspm_top
   import cspm_pkg::*;
#(
   parameter logic [2:0] SLOT_CODE = 3'h0,
   parameter logic [2:0] FIRST_WIN = 3'h0
)(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic [7:0] cfg_addr,
   input  wire logic       cfg_rd,
   output logic      [7:0] cfg_rdata,
   input  wire logic [1:0] pm_state,
   input  wire logic       wake_in_d3,
   input  wire logic       embedded_slot,
   input  wire logic       async_wake_perm,
   input  wire logic       wake_line_sel,
   input  wire logic       bus_wide_req,
   input  wire logic       pwr_wr,
   input  wire logic       pwr_wdata,
   input  wire logic       clk_wr,
   input  wire logic       clk_wdata,
   input  wire logic       state_chg_ack,
   input  wire logic       card_present_pin,
   output logic            card_bus_power_on,
   output logic            card_clock_gate_on,
   output logic            card_power_en,
   output logic            card_clk_run,
   output logic            bus_wide_ok,
   output logic            host_io_rail,
   output logic            bus_xfer_allowed,
   output logic            state_chg_irq
);

   // ----------------------------------------
   // Slot information byte
   // ----------------------------------------
   cspm_slot_info #(
      .SLOT_CODE (SLOT_CODE),
      .FIRST_WIN (FIRST_WIN)
   ) u_slot_info (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .cfg_addr  (cfg_addr),
      .cfg_rd    (cfg_rd),
      .cfg_rdata (cfg_rdata)
   );

   // ----------------------------------------
   // Card detect synchroniser
   // ----------------------------------------
   logic present_meta_r;
   logic present_sync_r;

   // Two flops before the detect pin is looked at
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         present_meta_r <= 1'b0;
         present_sync_r <= 1'b0;
      end else begin
         present_meta_r <= card_present_pin;
         present_sync_r <= present_meta_r;
      end
   end

   // ----------------------------------------
   // Power state tracking
   // ----------------------------------------
   logic [1:0] dstate_r;
   logic       irq_r;
   logic       irq_nxt;

   // Decoded view of the tracked power state
   wire state_changed = (pm_state != dstate_r);
   wire in_d0         = (dstate_r == CSPM_PS_D0);
   wire in_d1         = (dstate_r == CSPM_PS_D1);
   wire in_d3         = (dstate_r == CSPM_PS_D3);
   wire clock_allowed = in_d0 || in_d1;

   // A new change wins over an acknowledge in the same cycle
   assign irq_nxt = state_changed ? 1'b1 : (state_chg_ack ? 1'b0 : irq_r);

   // State follows the power field one clock later
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dstate_r <= CSPM_PS_D0;
         irq_r    <= 1'b0;
      end else begin
         dstate_r <= pm_state;
         irq_r    <= irq_nxt;
      end
   end

   // ----------------------------------------
   // Card presence and removal detection
   // ----------------------------------------
   cspm_card_t card_r;
   cspm_card_t card_nxt;
   logic       power_r;
   logic       clock_r;

   wire removed_powered = (card_r == CSPM_POWERED) && !present_sync_r;

   // Track whether power was applied while the card sat in the slot
   always_comb begin
      card_nxt = card_r;
      case (card_r)
         CSPM_EMPTY: begin
            if (present_sync_r) begin
               card_nxt = CSPM_PRESENT;
            end
         end
         CSPM_PRESENT: begin
            if (!present_sync_r) begin
               card_nxt = CSPM_EMPTY;
            end else if (power_r) begin
               card_nxt = CSPM_POWERED;
            end
         end
         CSPM_POWERED: begin
            if (!present_sync_r) begin
               card_nxt = CSPM_EMPTY;
            end
         end
         default: begin
            card_nxt = CSPM_EMPTY;
         end
      endcase
   end

   // Presence state register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         card_r <= CSPM_EMPTY;
      end else begin
         card_r <= card_nxt;
      end
   end

   // ----------------------------------------
   // Power and clock gate bits
   // ----------------------------------------
   logic power_nxt;
   logic clock_nxt;

   // Removal of a powered card clears both bits and overrides a driver write
   assign power_nxt = removed_powered ? 1'b0 :
                      (pwr_wr ? pwr_wdata : power_r);
   assign clock_nxt = removed_powered ? 1'b0 :
                      (clk_wr ? clk_wdata : clock_r);

   // Driver-visible bits; reset leaves power and clock off
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         power_r <= CSPM_POWER_RST;
         clock_r <= CSPM_CLOCK_RST;
      end else begin
         power_r <= power_nxt;
         clock_r <= clock_nxt;
      end
   end

   // ----------------------------------------
   // Pin-facing outputs
   // ----------------------------------------
   // Power follows the bit in every state; driver holds it in D1, D2, D3
   wire power_live = power_r && !removed_powered;
   // Wake in D3 needs card power held regardless of the bit
   wire power_hold = in_d3 && wake_in_d3 && present_sync_r;
   // Clock runs only in D0 or D1 with the gate bit set
   wire clk_live   = clock_r && clock_allowed && !removed_powered;
   // Narrow bus needed in D2 or D3 when wake is used without async permission, except an embedded slot with wake_line_sel set
   wire need_narrow = !in_d0 && !in_d1 && wake_in_d3 && !async_wake_perm &&
                      (!embedded_slot || !wake_line_sel);
   wire wide_ok     = bus_wide_req && !need_narrow;

   // Registered so the card-side switches never see decode glitches
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         card_power_en    <= 1'b0;
         card_clk_run     <= 1'b0;
         bus_wide_ok      <= 1'b0;
         host_io_rail     <= 1'b0;
         bus_xfer_allowed <= 1'b0;
      end else begin
         card_power_en    <= power_live || power_hold;
         card_clk_run     <= clk_live;
         bus_wide_ok      <= wide_ok;
         host_io_rail     <= embedded_slot || !in_d3 || power_live;
         bus_xfer_allowed <= in_d0 && power_live && clk_live;
      end
   end

   // Register bits and change request as the driver reads them
   assign card_bus_power_on  = power_r;
   assign card_clock_gate_on = clock_r;
   assign state_chg_irq      = irq_r;

endmodule

// file: dv/cspm_top_sva.sv
// Checker for the card slot power and clock logic
`timescale 1ns/1ps
module cspm_top_sva
   import cspm_pkg::*;
#(
   parameter logic [2:0] SLOT_CODE = 3'h0,
   parameter logic [2:0] FIRST_WIN = 3'h0
)(
   input wire logic       sys_clk,
   input wire logic       srst,
   input wire logic [7:0] cfg_addr,
   input wire logic       cfg_rd,
   input wire logic [7:0] cfg_rdata,
   input wire logic [1:0] pm_state,
   input wire logic       wake_in_d3,
   input wire logic       embedded_slot,
   input wire logic       async_wake_perm,
   input wire logic       wake_line_sel,
   input wire logic       bus_wide_req,
   input wire logic       pwr_wr,
   input wire logic       pwr_wdata,
   input wire logic       card_present_pin,
   input wire logic       card_bus_power_on,
   input wire logic       card_clock_gate_on,
   input wire logic       card_power_en,
   input wire logic       card_clk_run,
   input wire logic       bus_wide_ok,
   input wire logic       host_io_rail,
   input wire logic       bus_xfer_allowed,
   input wire logic       state_chg_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_slot_byte_read:
   assert property (cfg_rd && cfg_addr == CSPM_SLOT_INFO_OFFSET |=>
      cfg_rdata == {1'b0, SLOT_CODE, 1'b0, FIRST_WIN}) else $error("slot byte wrong");
   a_power_bit_write:
   assert property (pwr_wr && card_present_pin && $past(card_present_pin) &&
      $past(card_present_pin, 2) |=> card_bus_power_on == $past(pwr_wdata))
      else $error("power bit not written");
   a_clock_gated_low:
   assert property (pm_state[1] [*3] |-> !card_clk_run) else $error("clock runs in D2 or D3");
   a_clock_runs_on:
   assert property ((!pm_state[1] && card_clock_gate_on && card_power_en && card_present_pin)
      [*3] |-> card_clk_run) else $error("clock stopped in D0 or D1");
   a_d3_wake_power:
   assert property ((pm_state == CSPM_PS_D3 && wake_in_d3 && card_bus_power_on &&
      card_present_pin) [*3] |-> card_power_en) else $error("power lost in D3 with wake");
   a_removal_clears:
   assert property ($fell(card_present_pin) && card_bus_power_on |->
      ##[1:4] !card_bus_power_on && !card_clock_gate_on) else $error("removal not cleared");
   a_state_change_irq:
   assert property ($changed(pm_state) |-> ##[1:2] state_chg_irq) else $error("no state irq");
   a_xfer_only_d0:
   assert property ((pm_state != CSPM_PS_D0) [*3] |-> !bus_xfer_allowed)
      else $error("transfer allowed outside D0");
   a_embedded_io_rail:
   assert property (embedded_slot [*3] |-> host_io_rail) else $error("io rail off");
   a_narrow_wake_bus:
   assert property ((pm_state[1] && wake_in_d3 && !async_wake_perm && !wake_line_sel)
      [*3] |-> !bus_wide_ok) else $error("wide bus kept while asleep with wake");
   a_async_wide_ok:
   assert property ((bus_wide_req && async_wake_perm) [*3] |-> bus_wide_ok)
      else $error("wide bus refused with async wake");
endmodule

bind cspm_top cspm_top_sva #(.SLOT_CODE(SLOT_CODE), .FIRST_WIN(FIRST_WIN)) u_sva (.*);

// file: dv/cspm_card_model.sv
// Card model: drives the detect pin as the card goes in and out
`timescale 1ns/1ps
module cspm_card_model (
   input  wire logic sys_clk,
   input  wire logic insert_req,
   output logic      card_present_pin
);
   // Detect pin is a level, held low for as long as the card is out
   always_ff @(posedge sys_clk) card_present_pin <= insert_req;
endmodule

// file: dv/cspm_top_tb.sv
// Testbench for the card slot power and clock logic
`timescale 1ns/1ps
module cspm_top_tb;
   import cspm_pkg::*;
   localparam logic [2:0] SC = 3'h3;
   localparam logic [2:0] FW = 3'h2;
   logic       sys_clk, srst, cfg_rd, wake_in_d3, embedded_slot, async_wake_perm;
   logic       wake_line_sel, bus_wide_req, pwr_wr, pwr_wdata, clk_wr, clk_wdata;
   logic       state_chg_ack, insert_req, card_present_pin, card_bus_power_on;
   logic       card_clock_gate_on, card_power_en, card_clk_run, bus_wide_ok;
   logic       host_io_rail, bus_xfer_allowed, state_chg_irq, rd_d;
   logic [7:0] cfg_addr, cfg_rdata;
   logic [1:0] pm_state;
   logic [7:0] exp_q[$];
   int         err_total, total_checks;
   integer     seed;

   cspm_top #(.SLOT_CODE(SC), .FIRST_WIN(FW)) u_dut (.*);
   cspm_card_model u_card (.*);

   always #5 sys_clk = ~sys_clk;

   task automatic chk1(string nm, logic exp, logic got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %b got %b", nm, exp, got);
      end
   endtask

   task automatic chk8(string nm, logic [7:0] exp, logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask

   // Read answer lands one cycle after the strobe; compare with oldest note
   always @(posedge sys_clk) rd_d <= cfg_rd & ~srst;
   always @(negedge sys_clk) begin
      if (rd_d) begin
         chk8("cfg_rdata", exp_q.pop_front(), cfg_rdata);
      end
   end

   task automatic cyc(int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic cfg_read(logic [7:0] a);
      cfg_addr = a;
      cfg_rd = 1;
      exp_q.push_back(a == CSPM_SLOT_INFO_OFFSET ? {1'b0, SC, 1'b0, FW} : 8'h00);
      cyc(1);
   endtask

   // Move to a power state, expect the change request, then acknowledge it
   task automatic go(logic [1:0] s);
      pm_state = s;
      for (int i = 0; i < 8 && state_chg_irq !== 1'b1; i++) cyc(1);
      chk1("state_chg_irq", 1'b1, state_chg_irq);
      if (state_chg_irq !== 1'b1) test_done();
      state_chg_ack = 1;
      cyc(1);
      state_chg_ack = 0;
      cyc(2);
      chk1("irq_clear", 1'b0, state_chg_irq);
      $display("state %0d done", s);
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #100000;
      err_total++;
      test_done();
   end

   initial begin
      seed = 94;
      {sys_clk, cfg_rd, pwr_wr, pwr_wdata, clk_wr, clk_wdata, state_chg_ack} = '0;
      {wake_in_d3, embedded_slot, async_wake_perm, wake_line_sel, bus_wide_req} = '0;
      srst = 1;
      insert_req = 1;
      pm_state = CSPM_PS_D0;
      cfg_addr = 8'h00;
      err_total = 0;
      total_checks = 0;
      cyc(6);
      srst = 0;
      chk1("reset_power", CSPM_POWER_RST, card_bus_power_on);
      // Back to back reads, random addresses mixed with the slot byte
      for (int i = 0; i < 24; i++) begin
         cfg_read(i % 3 ? 8'($random(seed)) : CSPM_SLOT_INFO_OFFSET);
         {embedded_slot, async_wake_perm, wake_line_sel, bus_wide_req} = 4'($random(seed));
      end
      cfg_rd = 0;
      embedded_slot = 1;
      {async_wake_perm, wake_line_sel} = 2'b00;
      bus_wide_req = 1;
      cyc(2);
      $display("config reads done");
      // Power bit, then clock gate bit, with the card in
      pwr_wr = 1;
      pwr_wdata = 1;
      cyc(1);
      pwr_wr = 0;
      clk_wr = 1;
      clk_wdata = 1;
      cyc(1);
      clk_wr = 0;
      cyc(3);
      chk1("card_power_en", 1'b1, card_power_en);
      chk1("card_clk_run", 1'b1, card_clk_run);
      chk1("bus_xfer", 1'b1, bus_xfer_allowed);
      chk1("host_io_rail", 1'b1, host_io_rail);
      chk1("d0_wide", 1'b1, bus_wide_ok);
      $display("power bits done");
      go(CSPM_PS_D1);
      chk1("d1_clk", 1'b1, card_clk_run);
      chk1("d1_xfer", 1'b0, bus_xfer_allowed);
      chk1("d1_wide", 1'b1, bus_wide_ok);
      go(CSPM_PS_D2);
      chk1("d2_clk", 1'b0, card_clk_run);
      chk1("d2_gate", 1'b1, card_clock_gate_on);
      chk1("d2_power", 1'b1, card_power_en);
      wake_in_d3 = 1;
      go(CSPM_PS_D3);
      chk1("d3_clk", 1'b0, card_clk_run);
      chk1("d3_power", 1'b1, card_power_en);
      chk1("d3_narrow", 1'b0, bus_wide_ok);
      async_wake_perm = 1;
      cyc(2);
      chk1("d3_async_wide", 1'b1, bus_wide_ok);
      // Clear the power bit: wake support must keep the supply up
      pwr_wr = 1;
      pwr_wdata = 0;
      cyc(1);
      pwr_wr = 0;
      cyc(2);
      chk1("d3_hold", 1'b1, card_power_en);
      chk1("d3_io_rail", 1'b1, host_io_rail);
      // Cold state: wake dropped, back-end supply goes off
      wake_in_d3 = 0;
      cyc(3);
      chk1("d3_cold_power", 1'b0, card_power_en);
      pwr_wr = 1;
      pwr_wdata = 1;
      cyc(1);
      pwr_wr = 0;
      wake_in_d3 = 1;
      cyc(2);
      chk1("d3_power_back", 1'b1, card_power_en);
      // Pull the card while powered in D3
      insert_req = 0;
      cyc(6);
      chk1("rm_power_bit", 1'b0, card_bus_power_on);
      chk1("rm_gate_bit", 1'b0, card_clock_gate_on);
      chk1("rm_supply", 1'b0, card_power_en);
      $display("removal done");
      insert_req = 1;
      go(CSPM_PS_D0);
      chk1("d0_clk_off", 1'b0, card_clk_run);
      test_done();
   end
endmodule
